// [rtl/lsh_lin_slave_header_check.sv]
// lin slave receiver with header supervision, auto baud resync and apb register slave
//
// Function
// - identifier parity checked only in lin slave mode with parity check on
// - third character after a break, break counted first, is the identifier
// - identifier bits 7 and 8 are the parity bits
// - invalid header sets header error; interrupt if rx irq on and cpu mask clear
// - header error cleared by status read then data read
// - while locked, header error stays; clear lock first, then header error
// - resync off: error on overrun, synch byte not 55h, timeout in id mode
// - resync on: error on deviation beyond band or overrun outside synch
// - synch measurement overflow sets header error and locks the block
// - deviation measured first to last falling edge, flagged above 15.625%
// - each synch edge interval checked against current bit time, failure locks
// - header longer than 57 slave bits flags timeout, in id mode or resync
// - timeout counter starts at break, stops at id, other error, lock clear
// - timeout in synch with resync locks; otherwise header dropped, seek break
// - measured header length readable when id mode or resync enabled
// - mute id mode: synch error or timeout flags without wake, header dropped
// - in mute, framing error on non-break data is dropped silently
// - id mode wakes on valid break, clean synch, id without framing error, no timeout
// - resync times five falling edges into 15-bit count, updates divider
// - receiver halted and nothing transferred during synch measurement
// - rate is clock over sixteen times divider; 8-bit mantissa, 4-bit fraction
// - software divider write wins over measured update in same cycle
// - break mode: break sets rx full and break seen with data 00
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module lsh_lin_slave_header_check (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // lin bus and cpu
   input  wire logic        serialRxIn,
   input  wire logic [1:0]  cpuCondMask,
   output logic             irqReq
);

   lsh_pkg::lsh_state_s q, d;

   logic        apbWr;
   logic        apbRd;
   logic        hit;
   logic [11:0] divRaw;
   logic [12:0] accSum;
   logic        sTick;
   logic        bitTick;
   logic        fallEdge;
   logic        charDone;
   logic        charFe;
   logic        brkDet;
   logic        linSlave;
   logic        hdrWatch;
   logic        rxHalt;
   logic        xferOk;
   logic [14:0] smRef;
   logic [14:0] smDiff;
   logic [14:0] smBand;
   logic [14:0] smIntv;
   logic        devErr;
   logic        shortErr;
   logic        p0;
   logic        p1;

   // index of the fifth falling edge, counted from zero
   localparam logic [2:0] SYNC_LAST = lsh_pkg::SYNC_EDGES - 3'd1;

   // combinational helpers shared by the next-state logic
   assign apbWr    = psel & penable & pwrite;
   assign apbRd    = psel & penable & ~pwrite;
   assign divRaw   = {q.mant, q.frac};
   assign accSum   = {1'b0, q.acc} + lsh_pkg::ACC_STEP;
   // one sample tick per divider/16 clocks, so a bit lasts divider clocks
   assign sTick    = (divRaw != 12'h000) && (accSum >= {1'b0, divRaw});
   assign bitTick  = sTick && (q.hdrSub == 4'hf);
   assign fallEdge = q.rxPrev & ~serialRxIn;
   assign linSlave = q.ctrl[lsh_pkg::CTL_LIN_ON] & q.ctrl[lsh_pkg::CTL_SLAVE_SEL];
   assign hdrWatch = q.ctrl[lsh_pkg::CTL_HDR_SEL] | q.ctrl[lsh_pkg::CTL_RESYNC_ON];
   assign rxHalt   = (q.hdrSt == lsh_pkg::H_SYNC) && q.ctrl[lsh_pkg::CTL_RESYNC_ON];

   // synch field checks: eight bit times nominally take eight times the divider
   assign smRef    = {divRaw, 3'b000};
   assign smDiff   = (q.smCnt > smRef) ? (q.smCnt - smRef) : (smRef - q.smCnt);
   assign smBand   = {3'b000, divRaw} + {5'b00000, divRaw[11:2]};
   assign devErr   = smDiff > smBand;
   assign smIntv   = q.smCnt - q.smLast;
   // falling edges of 55h are two bits apart; under one bit means far too fast
   assign shortErr = (q.smEdges != 3'd0) && (smIntv < {3'b000, divRaw});

   // lin identifier parity over the received byte
   assign p0 = q.shReg[0] ^ q.shReg[1] ^ q.shReg[2] ^ q.shReg[4];
   assign p1 = ~(q.shReg[1] ^ q.shReg[3] ^ q.shReg[4] ^ q.shReg[5]);

   // apb: zero wait state, error on unmapped offsets
   always_comb begin
      hit    = 1'b1;
      prdata = 32'h0000_0000;
      unique case (paddr)
         lsh_pkg::OFF_CTRL:   prdata = {23'h000000, q.lock, q.ctrl};
         lsh_pkg::OFF_STATUS: prdata = {24'h000000, q.ctrl[lsh_pkg::CTL_MUTE], q.lock, q.brkSeen, q.ovrErr,
                                        q.parErr, q.frameErr, q.hdrErr, q.rxFull};
         lsh_pkg::OFF_DATA:   prdata = {24'h000000, q.rxData};
         lsh_pkg::OFF_MANT:   prdata = {24'h000000, q.mant};
         lsh_pkg::OFF_FRAC:   prdata = {28'h0000000, q.frac};
         lsh_pkg::OFF_HLEN:   prdata = hdrWatch ? {24'h000000, q.hdrLenReg} : 32'h0000_0000;
         default:             hit = 1'b0;
      endcase
      if (!hit) begin
         prdata = 32'h0000_0000;
      end
   end
   // no wait states on any register
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~hit;

   // receive interrupt request gated by the cpu mask bits
   assign irqReq = ((q.ctrl[lsh_pkg::CTL_RXIRQ_ON] & (q.rxFull | q.hdrErr | q.ovrErr))
                   | (q.ctrl[lsh_pkg::CTL_BRKIRQ_ON] & q.brkSeen)) & ~|cpuCondMask;

   // next-state logic; clears come first so that later hardware sets win
   always_comb begin
      d        = q;
      charDone = 1'b0;
      charFe   = 1'b0;
      brkDet   = 1'b0;
      xferOk   = 1'b0;
      d.rxPrev = serialRxIn;
      // sixteen per clock against the 8.4 divider
      d.acc    = sTick ? 12'(accSum - {1'b0, divRaw}) : ((divRaw == 12'h000) ? 12'h000 : accSum[11:0]);

      // ---- software side ----
      if (apbWr && paddr == lsh_pkg::OFF_CTRL) begin
         d.ctrl = pwdata[7:0];
         // lock can only be released by software, never set
         if (q.lock && !pwdata[lsh_pkg::CTL_LOCK]) begin
            d.lock = 1'b0;
            d.hdrOn = 1'b0;
            d.hdrSt = lsh_pkg::H_IDLE;
         end
      end
      if (apbRd && paddr == lsh_pkg::OFF_STATUS) begin
         d.stsArm = 1'b1;
      end
      if (apbRd && paddr == lsh_pkg::OFF_DATA && q.stsArm) begin
         d.stsArm   = 1'b0;
         d.rxFull   = 1'b0;
         d.brkSeen  = 1'b0;
         d.frameErr = 1'b0;
         d.parErr   = 1'b0;
         d.ovrErr   = 1'b0;
         // header error survives while the block is locked
         if (!q.lock) begin
            d.hdrErr = 1'b0;
         end
      end

      // ---- character receiver, sampling at the middle of each bit ----
      unique case (q.rxSt)
         lsh_pkg::RX_IDLE: begin
            // start needs a fresh falling edge
            if (!rxHalt && fallEdge) begin
               d.rxSt    = lsh_pkg::RX_BITS;
               d.sampCnt = 4'h0;
               d.bitIdx  = 4'h0;
               d.lowBits = 8'h00;
            end
         end
         lsh_pkg::RX_BITS: begin
            if (sTick) begin
               d.sampCnt = q.sampCnt + 4'h1;
               if (q.sampCnt == lsh_pkg::SAMPLE_POINT) begin
                  d.bitIdx = q.bitIdx + 4'h1;
                  if (!serialRxIn) begin
                     d.lowBits = q.lowBits + 8'h01;
                  end
                  if (q.bitIdx == 4'h0 && serialRxIn) begin
                     d.rxSt = lsh_pkg::RX_IDLE;                  // false start bit
                  end else if (q.bitIdx == lsh_pkg::STOP_BIT_IDX) begin
                     if (q.shReg == 8'h00 && !serialRxIn) begin
                        d.rxSt = lsh_pkg::RX_BRK;
                     end else begin
                        d.rxSt   = lsh_pkg::RX_IDLE;
                        charDone = 1'b1;
                        charFe   = ~serialRxIn;
                     end
                  end else if (q.bitIdx != 4'h0) begin
                     d.shReg = {serialRxIn, q.shReg[7:1]};
                  end
               end
            end
         end
         lsh_pkg::RX_BRK: begin
            // a break needs at least eleven low bits and then a high level
            if (serialRxIn) begin
               d.rxSt = lsh_pkg::RX_IDLE;
               if (q.lowBits >= lsh_pkg::BRK_MIN_BITS) begin
                  brkDet = 1'b1;
               end else begin
                  charDone = 1'b1;
                  charFe   = 1'b1;
               end
            end else if (sTick) begin
               d.sampCnt = q.sampCnt + 4'h1;
               if (q.sampCnt == lsh_pkg::SAMPLE_POINT && q.lowBits != 8'hff) begin
                  d.lowBits = q.lowBits + 8'h01;
               end
            end
         end
         default: d.rxSt = lsh_pkg::RX_IDLE;
      endcase

      // ---- header timeout, counted in slave bit times from the break ----
      if (sTick) begin
         d.hdrSub = q.hdrSub + 4'h1;
      end
      if (q.hdrOn && hdrWatch && bitTick && q.hdrLen != 8'hff) begin
         d.hdrLen = q.hdrLen + 8'h01;
         if (q.hdrLen == lsh_pkg::HDR_MAX_BITS) begin
            d.hdrErr = 1'b1;
            d.hdrOn  = 1'b0;
            d.hdrLenReg = q.hdrLen + 8'h01;
            if (q.hdrSt == lsh_pkg::H_SYNC && q.ctrl[lsh_pkg::CTL_RESYNC_ON]) begin
               d.lock  = 1'b1;
               d.hdrSt = lsh_pkg::H_BLOCK;
            end else begin
               d.hdrSt = lsh_pkg::H_IDLE;
            end
         end
      end

      // ---- header sequencer: break, synch, identifier ----
      if (!linSlave) begin
         d.hdrSt = lsh_pkg::H_IDLE;
         d.hdrOn = 1'b0;
      end else if (brkDet && q.hdrSt != lsh_pkg::H_BLOCK) begin
         // break is the first character of a header
         d.hdrSt   = lsh_pkg::H_SYNC;
         d.hdrOn   = 1'b1;
         d.hdrSub  = 4'h0;
         d.hdrLen  = q.lowBits + 8'h01;
         d.smCnt   = 15'h0000;
         d.smLast  = 15'h0000;
         d.smEdges = 3'd0;
         if (!q.ctrl[lsh_pkg::CTL_HDR_SEL]) begin
            d.rxFull  = 1'b1;
            d.brkSeen = 1'b1;
            d.rxData  = 8'h00;
            d.ctrl[lsh_pkg::CTL_MUTE] = 1'b0;
            if (q.rxFull) begin
               d.ovrErr = 1'b1;
            end
         end
      end else if (q.hdrSt == lsh_pkg::H_SYNC && q.ctrl[lsh_pkg::CTL_RESYNC_ON]) begin
         // measure five falling edges on the clock into a 15-bit count
         if (q.smEdges != 3'd0) begin
            d.smCnt = q.smCnt + 15'h0001;
            if (q.smCnt == 15'h7fff) begin
               d.hdrErr = 1'b1;
               d.lock   = 1'b1;
               d.hdrOn  = 1'b0;
               d.hdrSt  = lsh_pkg::H_BLOCK;
            end
         end
         if (fallEdge && q.smCnt != 15'h7fff) begin
            if (q.smEdges == 3'd0) begin
               // the first edge cycle belongs to the span
               d.smCnt = 15'h0001;
            end
            d.smEdges = q.smEdges + 3'd1;
            d.smLast  = q.smCnt;
            if (shortErr || (q.smEdges == SYNC_LAST && devErr)) begin
               d.hdrErr = 1'b1;
               d.lock   = 1'b1;
               d.hdrOn  = 1'b0;
               d.hdrSt  = lsh_pkg::H_BLOCK;
            end else if (q.smEdges == SYNC_LAST) begin
               // measured span is eight bits, so divider = count / 8
               d.mant  = q.smCnt[14:7];
               d.frac  = q.smCnt[6:3];
               d.hdrSt = lsh_pkg::H_ID;
            end
         end
      end else if (charDone && q.hdrSt == lsh_pkg::H_SYNC) begin
         // resync off: synch arrives as a plain character
         if (!q.ctrl[lsh_pkg::CTL_HDR_SEL] && !q.ctrl[lsh_pkg::CTL_MUTE]) begin
            xferOk = 1'b1;
         end
         if (q.shReg != lsh_pkg::SYNC_BYTE || charFe || (xferOk && d.rxFull)) begin
            d.hdrErr = 1'b1;
            d.hdrOn  = 1'b0;
            d.hdrSt  = lsh_pkg::H_IDLE;
         end else begin
            d.hdrSt = lsh_pkg::H_ID;
         end
      end else if (charDone && q.hdrSt == lsh_pkg::H_ID) begin
         d.hdrOn     = 1'b0;
         d.hdrLenReg = q.hdrLen;
         d.hdrSt     = lsh_pkg::H_IDLE;
         if (charFe) begin
            // bad identifier drops the header and does not wake
            d.frameErr = ~q.ctrl[lsh_pkg::CTL_MUTE] | q.frameErr;
         end else begin
            // parity sits in bits 7 and 8 of the identifier
            if (q.ctrl[lsh_pkg::CTL_PARITY_ON] && (p0 != q.shReg[6] || p1 != q.shReg[7])) begin
               d.parErr = 1'b1;
            end
            if (q.ctrl[lsh_pkg::CTL_HDR_SEL]) begin
               // parity errors still wake the receiver
               d.ctrl[lsh_pkg::CTL_MUTE] = 1'b0;
               d.brkSeen = 1'b1;
               xferOk    = 1'b1;
            end else if (!q.ctrl[lsh_pkg::CTL_MUTE]) begin
               xferOk = 1'b1;
            end
            if (xferOk && d.rxFull) begin
               d.hdrErr = 1'b1;
            end
         end
      end else if (charDone && q.hdrSt == lsh_pkg::H_IDLE && !q.ctrl[lsh_pkg::CTL_MUTE]) begin
         // ordinary data outside a header; mute drops it and its framing error
         xferOk = 1'b1;
         if (charFe) begin
            d.frameErr = 1'b1;
         end
      end

      // ---- transfer to the data register, overrun keeps the old byte ----
      // a data read after a status read frees the register in this cycle, so the byte lands
      if (xferOk) begin
         if (d.rxFull) begin
            d.ovrErr = 1'b1;
         end else begin
            d.rxFull = 1'b1;
            d.rxData = q.shReg;
         end
      end

      // software nominal divider lands last, so it beats a measured update
      if (apbWr && paddr == lsh_pkg::OFF_MANT) begin
         d.mant = pwdata[7:0];
      end
      if (apbWr && paddr == lsh_pkg::OFF_FRAC) begin
         d.frac = pwdata[3:0];
      end
   end

   // one register bank for the whole state
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         q           <= '0;
         q.mant      <= lsh_pkg::RST_MANT;
         q.frac      <= lsh_pkg::RST_FRAC;
         q.rxPrev    <= 1'b1;
         q.rxSt      <= lsh_pkg::RX_IDLE;
         q.hdrSt     <= lsh_pkg::H_IDLE;
      end else begin
         q <= d;
      end
   end

endmodule // lsh_lin_slave_header_check

// [inc/lsh_pkg.sv]
// package: register map, field positions, timing constants and state types of the lin slave header checker
package lsh_pkg;

   // register byte offsets on the apb bus
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_DATA   = 8'h08;
   localparam logic [7:0] OFF_MANT   = 8'h0c;
   localparam logic [7:0] OFF_FRAC   = 8'h10;
   localparam logic [7:0] OFF_HLEN   = 8'h14;

   // control register bit positions
   localparam int CTL_LIN_ON    = 0;
   localparam int CTL_SLAVE_SEL = 1;
   localparam int CTL_PARITY_ON = 2;
   localparam int CTL_RESYNC_ON = 3;
   localparam int CTL_HDR_SEL   = 4;
   localparam int CTL_MUTE      = 5;
   localparam int CTL_RXIRQ_ON  = 6;
   localparam int CTL_BRKIRQ_ON = 7;
   localparam int CTL_LOCK      = 8;

   // status register bit positions
   localparam int STS_RX_FULL   = 0;
   localparam int STS_HDR_ERR   = 1;
   localparam int STS_FRAME_ERR = 2;
   localparam int STS_PAR_ERR   = 3;
   localparam int STS_OVR_ERR   = 4;
   localparam int STS_BRK_SEEN  = 5;
   localparam int STS_LOCK      = 6;
   localparam int STS_MUTE      = 7;

   // reset values
   localparam logic [7:0] RST_MANT = 8'h00;
   localparam logic [3:0] RST_FRAC = 4'h0;

   // protocol figures
   localparam logic [7:0]  SYNC_BYTE     = 8'h55;
   localparam logic [7:0]  BRK_MIN_BITS  = 8'd11;
   localparam logic [7:0]  HDR_MAX_BITS  = 8'd57;
   localparam logic [2:0]  SYNC_EDGES    = 3'd5;
   localparam logic [3:0]  SAMPLE_POINT  = 4'd7;
   localparam logic [3:0]  STOP_BIT_IDX  = 4'd9;
   localparam logic [12:0] ACC_STEP      = 13'h0010;

   // receiver and header states, gray coded along the usual path
   typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_BITS = 2'b01, RX_BRK = 2'b11} lsh_rx_e;
   typedef enum logic [1:0] {H_IDLE = 2'b00, H_SYNC = 2'b01, H_ID = 2'b11, H_BLOCK = 2'b10} lsh_hdr_e;

   // whole state of the block
   typedef struct packed {
      logic [7:0]  ctrl;
      logic        lock;
      logic        hdrErr;
      logic        rxFull;
      logic        brkSeen;
      logic        frameErr;
      logic        parErr;
      logic        ovrErr;
      logic        stsArm;
      logic [7:0]  rxData;
      logic [7:0]  mant;
      logic [3:0]  frac;
      logic [11:0] acc;
      lsh_rx_e     rxSt;
      logic [3:0]  sampCnt;
      logic [3:0]  bitIdx;
      logic [7:0]  shReg;
      logic [7:0]  lowBits;
      logic        rxPrev;
      lsh_hdr_e    hdrSt;
      logic        hdrOn;
      logic [3:0]  hdrSub;
      logic [7:0]  hdrLen;
      logic [7:0]  hdrLenReg;
      logic [14:0] smCnt;
      logic [14:0] smLast;
      logic [2:0]  smEdges;
   } lsh_state_s;

endpackage

// [verification/lsh_lin_master.sv]
// behavioural lin master node driving break, synch and identifier fields
`timescale 1ns/100ps
module lsh_lin_master (
   // clock
   input  wire logic ref_clk,
   // lin bus, recessive high through the pull-up
   output logic      linLine
);
   // bus rests recessive outside frames
   initial linLine = 1'b1;

   // one level for n bit times, changed just after an edge
   task automatic hold(input logic v, input int n, input int bitClk);
      linLine <= v;
      repeat (n * bitClk) @(posedge ref_clk);
   endtask

   // start bit, eight data bits lsb first, one stop bit
   task automatic send_byte(input logic [7:0] b, input int bitClk);
      hold(1'b0, 1, bitClk);
      for (int i = 0; i < 8; i++)
         hold(b[i], 1, bitClk);
      hold(1'b1, 1, bitClk);
   endtask

   // thirteen dominant bits keep the break valid even for a fast slave
   task automatic send_break(input int bitClk);
      hold(1'b0, 13, bitClk);
      hold(1'b1, 1, bitClk);
   endtask

   // full header sent without gaps
   task automatic send_header(input logic [7:0] sync, input logic [7:0] id, input int bitClk);
      send_break(bitClk);
      send_byte(sync, bitClk);
      send_byte(id, bitClk);
   endtask
endmodule // lsh_lin_master

// [verification/lsh_lin_slave_header_check_sva.sv]
// assertion checker on the apb and interrupt ports of the header checker
`timescale 1ns/100ps
module lsh_lin_slave_header_check_sva (
   // clock and reset
   input wire logic        ref_clk,
   input wire logic        nrst,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // lin and cpu
   input wire logic        serialRxIn,
   input wire logic [1:0]  cpuCondMask,
   input wire logic        irqReq
);
   logic [7:0] ctrl_q;
   logic       acc;
   logic       mapped;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   // access phase and decode of the six word offsets
   assign acc = psel && penable;
   assign mapped = (paddr <= lsh_pkg::OFF_HLEN) && (paddr[1:0] == 2'b00);

   // shadow of the control byte, so gating is judged from the ports alone
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst)
         ctrl_q <= 8'h00;
      else if (acc && pwrite && paddr == lsh_pkg::OFF_CTRL)
         ctrl_q <= pwdata[7:0];
   end

   a_ready_zero_wait: assert property (psel |-> pready) else $error("pready low in a transfer");
   a_err_access_only: assert property (pslverr |-> acc) else $error("pslverr outside access");
   a_unmapped_err: assert property (acc && !mapped |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_mapped_no_err: assert property (acc && mapped |-> !pslverr) else $error("mapped access refused");
   a_irq_masked: assert property (cpuCondMask != 2'b00 |-> !irqReq) else $error("irq while masked");
   a_irq_disabled: assert property (ctrl_q[7:6] == 2'b00 |-> !irqReq) else $error("irq while off");
   a_hlen_gated: assert property (acc && paddr == lsh_pkg::OFF_HLEN && ctrl_q[4:3] == 2'b00 |-> prdata == 32'h0)
      else $error("length visible while gated");
   a_mant_width: assert property (acc && paddr == lsh_pkg::OFF_MANT |-> prdata[31:8] == 24'h0)
      else $error("mantissa wider than 8 bits");
   a_frac_width: assert property (acc && paddr == lsh_pkg::OFF_FRAC |-> prdata[31:4] == 28'h0)
      else $error("fraction wider than 4 bits");
   a_mant_written: assert property (acc && pwrite && paddr == lsh_pkg::OFF_MANT ##1 !psel
      ##1 psel && !penable && !pwrite && paddr == lsh_pkg::OFF_MANT ##1 acc
      |-> prdata[7:0] == $past(pwdata[7:0], 3)) else $error("mantissa write lost");

   c_unmapped: cover property (acc && !mapped);
   c_irq: cover property (irqReq);
   c_hlen_read: cover property (acc && paddr == lsh_pkg::OFF_HLEN && ctrl_q[4]);
endmodule // lsh_lin_slave_header_check_sva

bind lsh_lin_slave_header_check lsh_lin_slave_header_check_sva chk (.ref_clk(ref_clk), .nrst(nrst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .serialRxIn(serialRxIn), .cpuCondMask(cpuCondMask), .irqReq(irqReq));

// [verification/test_lin_slave_header_check.sv]
// self-checking bench for the lin slave header checker
`timescale 1ns/100ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin fails++; \
   $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp); end end
module test_lin_slave_header_check;
   logic        ref_clk;
   logic        nrst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        serialRxIn;
   logic [1:0]  cpuCondMask;
   logic        irqReq;
   logic [31:0] rd;
   logic        err;
   int          fails;
   int          total_checks;

   lsh_lin_slave_header_check dut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .serialRxIn(serialRxIn), .cpuCondMask(cpuCondMask), .irqReq(irqReq));
   lsh_lin_master lin (.ref_clk(ref_clk), .linLine(serialRxIn));

   // 100 mhz clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // one apb transfer; read data taken before that edge's updates land
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic get(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask

   // identifier with lin parity, optionally spoiled in the top bit
   function automatic logic [7:0] mk_id(input logic [5:0] i, input logic bad);
      logic p0;
      logic p1;
      p0 = i[0] ^ i[1] ^ i[2] ^ i[4];
      p1 = ~(i[1] ^ i[3] ^ i[4] ^ i[5]);
      return {p1 ^ bad, p0, i};
   endfunction

   // reset values, refusals and field widths
   task automatic t_regs;
      get(lsh_pkg::OFF_CTRL);
      `CHK(rd, 32'h0)
      get(8'h18);
      `CHK({err, rd}, 33'h1_0000_0000)
      wr(lsh_pkg::OFF_STATUS, 32'hff);
      get(lsh_pkg::OFF_STATUS);
      `CHK(rd, 32'h0)
      get(lsh_pkg::OFF_HLEN);
      `CHK(rd, 32'h0)
      wr(lsh_pkg::OFF_MANT, 32'hffff_ffff);
      get(lsh_pkg::OFF_MANT);
      `CHK(rd, 32'hff)
      wr(lsh_pkg::OFF_FRAC, 32'hffff_ffff);
      get(lsh_pkg::OFF_FRAC);
      `CHK(rd, 32'hf)
      wr(lsh_pkg::OFF_MANT, 32'h2);
      wr(lsh_pkg::OFF_FRAC, 32'h0);
   endtask

   // break detection mode, synch taken as a character
   task automatic t_brk;
      wr(lsh_pkg::OFF_CTRL, 32'h003);
      lin.send_break(32);
      get(lsh_pkg::OFF_STATUS);
      `CHK({rd[5], rd[0]}, 2'b11)
      get(lsh_pkg::OFF_DATA);
      `CHK(rd[7:0], 8'h00)
      lin.send_byte(8'h55, 32);
      get(lsh_pkg::OFF_STATUS);
      `CHK({rd[1], rd[0]}, 2'b01)
      get(lsh_pkg::OFF_DATA);
      `CHK(rd[7:0], 8'h55)
   endtask

   // identifier mode from mute: good id, bad parity, bad parity unchecked
   task automatic t_id;
      logic       bad;
      logic       parity_check_on;
      logic [7:0] id;
      for (int k = 0; k < 3; k++) begin
         bad = (k != 0);
         parity_check_on = (k != 2);
         id = mk_id(6'h15 + 6'(k), bad);
         wr(lsh_pkg::OFF_CTRL, {26'h0, 2'b11, 1'b0, parity_check_on, 2'b11});
         lin.send_header(8'h55, id, 32);
         get(lsh_pkg::OFF_STATUS);
         `CHK({rd[7], rd[5], rd[3], rd[1], rd[0]}, {2'b01, bad && parity_check_on, 2'b01})
         get(lsh_pkg::OFF_DATA);
         `CHK(rd[7:0], id)
         get(lsh_pkg::OFF_HLEN);
         `CHK(rd[7:0] inside {[8'd30:8'd57]}, 1'b1)
      end
   endtask

   // wrong synch byte: flag, interrupt, masking and the clear order
   task automatic t_syncerr;
      wr(lsh_pkg::OFF_CTRL, 32'h043);
      lin.send_break(32);
      get(lsh_pkg::OFF_STATUS);
      get(lsh_pkg::OFF_DATA);
      lin.send_byte(8'h54, 32);
      `CHK(irqReq, 1'b1)
      cpuCondMask <= 2'b10;
      @(posedge ref_clk);
      `CHK(irqReq, 1'b0)
      cpuCondMask <= 2'b00;
      get(lsh_pkg::OFF_DATA);
      get(lsh_pkg::OFF_STATUS);
      `CHK(rd[1], 1'b1)
      get(lsh_pkg::OFF_DATA);
      get(lsh_pkg::OFF_STATUS);
      `CHK(rd[1], 1'b0)
   endtask

   // header stalls past 57 bits, then a fresh header is accepted
   task automatic t_timeout;
      wr(lsh_pkg::OFF_CTRL, 32'h013);
      lin.send_break(32);
      lin.send_byte(8'h55, 32);
      repeat (45 * 32) @(posedge ref_clk);
      get(lsh_pkg::OFF_STATUS);
      `CHK({rd[6], rd[1], rd[0]}, 3'b010)
      get(lsh_pkg::OFF_DATA);
      lin.send_header(8'h55, mk_id(6'h2a, 1'b0), 32);
      get(lsh_pkg::OFF_STATUS);
      `CHK({rd[1], rd[0]}, 2'b01)
      get(lsh_pkg::OFF_DATA);
   endtask

   // resync: 25% slow master locks, 12.5% slow master retunes the divider
   task automatic t_resync;
      wr(lsh_pkg::OFF_CTRL, 32'h01b);
      lin.send_header(8'h55, mk_id(6'h01, 1'b0), 40);
      get(lsh_pkg::OFF_STATUS);
      `CHK({rd[6], rd[1]}, 2'b11)
      get(lsh_pkg::OFF_DATA);
      get(lsh_pkg::OFF_STATUS);
      `CHK(rd[1], 1'b1)
      wr(lsh_pkg::OFF_CTRL, 32'h01b);
      get(lsh_pkg::OFF_DATA);
      get(lsh_pkg::OFF_STATUS);
      `CHK({rd[6], rd[1]}, 2'b00)
      wr(lsh_pkg::OFF_MANT, 32'h2);
      wr(lsh_pkg::OFF_FRAC, 32'h0);
      lin.send_header(8'h55, mk_id(6'h01, 1'b0), 36);
      get(lsh_pkg::OFF_MANT);
      `CHK(rd, 32'h2)
      get(lsh_pkg::OFF_FRAC);
      `CHK(rd, 32'h4)
      get(lsh_pkg::OFF_STATUS);
      `CHK({rd[1], rd[0]}, 2'b01)
      get(lsh_pkg::OFF_DATA);
      `CHK(rd[7:0], mk_id(6'h01, 1'b0))
   endtask

   // mute drops the framing error of a short low run
   task automatic t_mute;
      wr(lsh_pkg::OFF_CTRL, 32'h023);
      lin.hold(1'b0, 10, 36);
      lin.hold(1'b1, 2, 36);
      get(lsh_pkg::OFF_STATUS);
      `CHK({rd[2], rd[0]}, 2'b00)
   endtask

   // verdict and end of run
   task automatic conclude;
      if (fails == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // main sequence after four cycles of reset
   initial begin
      fails = 0;
      total_checks = 0;
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      cpuCondMask = 2'b00;
      repeat (4) @(posedge ref_clk);
      nrst <= 1'b1;
      @(posedge ref_clk);
      t_regs;
      t_brk;
      t_id;
      t_syncerr;
      t_timeout;
      t_resync;
      t_mute;
      conclude;
   end

   // watchdog, some four times the expected run
   initial begin
      #500_000;
      fails++;
      conclude;
   end
endmodule // test_lin_slave_header_check
